// ===== hw/gpt_defs.svh
// Register offsets, field positions, reset values and timing counts of the timer unit.
// Included by the timer unit; defines only.
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH

`define GPT_CTL_BASE 8'h00
`define GPT_VAL_BASE 8'h14
`define GPT_CAPTURE_RELOAD_REG 8'h28
`define GPT_NODE_BASE 8'h2C

`define GPT_SEL_HI 2
`define GPT_SEL_LO 0
`define GPT_MODE_HI 5
`define GPT_MODE_LO 3
`define GPT_RUN 6
`define GPT_DOWN 7
`define GPT_EXTDIR 8
`define GPT_OUTEN 9
`define GPT_RLDEN 8
`define GPT_LATCH 10
`define GPT_CEDGE_HI 9
`define GPT_CEDGE_LO 8
`define GPT_CSRC_HI 11
`define GPT_CSRC_LO 10
`define GPT_CAPEN 12
`define GPT_CAPCLR 13
`define GPT_CTL_WMASK 16'hFBFF

`define GPT_PRIO_HI 3
`define GPT_PRIO_LO 0
`define GPT_IE 6
`define GPT_IR 7

`define GPT_CTL_RST 16'h0000
`define GPT_VAL_RST 16'h0000
`define GPT_NODE_RST 8'h00

`define GPT_CLK_NS 100
`define GPT_TCL_NS 50
`define FIRST_TIMER_MODULE_RES_TCL 16
`define SECOND_TIMER_MODULE_RES_TCL 8
`define FIRST_TIMER_MODULE_RES_CYC ((`FIRST_TIMER_MODULE_RES_TCL * `GPT_TCL_NS + `GPT_CLK_NS - 1) / `GPT_CLK_NS)
`define SECOND_TIMER_MODULE_RES_CYC ((`SECOND_TIMER_MODULE_RES_TCL * `GPT_TCL_NS + `GPT_CLK_NS - 1) / `GPT_CLK_NS)

`endif

// ===== hw/gpt_pkg.sv
// Types shared by the timer unit: operating modes and the pin bundle.
// No surroundings assumed.
package gpt_pkg;

    typedef enum logic [2:0] {
        GPT_TIMER   = 3'b000,
        GPT_COUNTER = 3'b001,
        GPT_GATE_LO = 3'b010,
        GPT_GATE_HI = 3'b011,
        GPT_RELOAD  = 3'b100,
        GPT_CAPTURE = 3'b101,
        GPT_INCR    = 3'b110
    } gpt_mode_t;

    // Index 0 aux low, 1 core, 2 aux high
    typedef struct packed {
        logic [2:0] timer_input_pin;
        logic [2:0] direction_input_pin;
        logic capture_input_pin;
    } gpt_pins_t;

endpackage

// ===== hw/gpt_unit.sv
// Five 16-bit timers in two modules behind a classic Wishbone slave.
// Assumes asynchronous pins and an aligned 32-bit Wishbone master on clk_i.
`timescale 1ns/1ps
`include "gpt_defs.svh"
module gpt_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire gpt_pkg::gpt_pins_t pins_i,
    output logic toggle_output_pin_o,
    output logic [5:0] node_req_o
);

    localparam int unsigned G1_SH = $clog2(`FIRST_TIMER_MODULE_RES_CYC);
    localparam int unsigned G2_SH = $clog2(`SECOND_TIMER_MODULE_RES_CYC);

    function automatic logic pre_tick(input logic [15:0] cnt, input logic [3:0] sh);
        logic [15:0] m;
        m = 16'((17'h00001 << sh) - 17'h00001);
        return &(cnt | ~m);
    endfunction

    function automatic logic edge_hit(input logic [1:0] s, input logic r, input logic f);
        return (s[0] & r) | (s[1] & f);
    endfunction

    function automatic logic [15:0] step(input logic [15:0] v, input logic dn);
        return dn ? v - 16'h0001 : v + 16'h0001;
    endfunction

    function automatic logic wraps(input logic [15:0] v, input logic dn);
        return dn ? (v == 16'h0000) : (v == 16'hFFFF);
    endfunction

    function automatic logic [15:0] lanes(input logic [15:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction

    // Timer index: 0 aux low, 1 core, 2 aux high, 3 second aux, 4 second core
    logic [15:0] ctl_r [5];
    logic [15:0] val_r [5];
    logic [15:0] capture_reload_reg_r;
    logic [7:0] node_r [6];
    logic core_toggle_latch_r;
    logic second_toggle_latch_r;
    logic [1:0] otl_ev_r;
    logic sotl_ev_r;
    logic out_r;
    logic [5:0] req_r;
    logic [15:0] pre_r;
    logic ack_r;
    logic [31:0] dat_r;
    gpt_pkg::gpt_pins_t sync1_r;
    gpt_pkg::gpt_pins_t sync2_r;
    gpt_pkg::gpt_pins_t sync3_r;
    gpt_pkg::gpt_pins_t rise;
    gpt_pkg::gpt_pins_t fall;

    logic wr;
    logic [4:0] wr_ctl;
    logic [4:0] wr_val;
    logic wr_cap;
    logic [5:0] wr_node;
    logic [31:0] rdata;
    logic [4:0] en;
    logic [4:0] dn;
    logic [4:0] wrap;
    logic [2:0] cap;
    logic [2:0] rld;
    logic [2:0] rld_arm;
    logic otl_rise;
    logic otl_fall;
    logic scap;
    logic [5:0] ev;

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign toggle_output_pin_o = out_r;
    assign node_req_o = req_r;

    // Pin synchroniser; stage three only serves edge detection
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= pins_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~sync3_r;
    assign fall = ~sync2_r & sync3_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_r <= 16'h0000;
        end else begin
            pre_r <= pre_r + 16'h0001;
        end
    end

    // Bus decode and read mux
    always_comb begin
        wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
        wr_cap = wr && (wb_adr_i == `GPT_CAPTURE_RELOAD_REG);
        rdata = 32'h00000000;
        if (wb_adr_i == `GPT_CAPTURE_RELOAD_REG) begin
            rdata = {16'h0000, capture_reload_reg_r};
        end
        for (int i = 0; i < 5; i++) begin
            wr_ctl[i] = wr && (wb_adr_i == `GPT_CTL_BASE + 8'(4 * i));
            wr_val[i] = wr && (wb_adr_i == `GPT_VAL_BASE + 8'(4 * i));
            if (wb_adr_i == `GPT_CTL_BASE + 8'(4 * i)) begin
                rdata = {16'h0000, ctl_r[i]};
            end
            if (wb_adr_i == `GPT_VAL_BASE + 8'(4 * i)) begin
                rdata = {16'h0000, val_r[i]};
            end
        end
        if (wb_adr_i == `GPT_CTL_BASE + 8'h04) begin
            rdata[`GPT_LATCH] = core_toggle_latch_r;
        end
        if (wb_adr_i == `GPT_CTL_BASE + 8'h10) begin
            rdata[`GPT_LATCH] = second_toggle_latch_r;
        end
        for (int j = 0; j < 6; j++) begin
            wr_node[j] = wr && (wb_adr_i == `GPT_NODE_BASE + 8'(4 * j));
            if (wb_adr_i == `GPT_NODE_BASE + 8'(4 * j)) begin
                rdata = {24'h000000, node_r[j]};
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
            dat_r <= rdata;
        end
    end

    // Count enables and directions
    always_comb begin
        logic [2:0] sel;
        logic a;
        logic b;
        logic ca;
        logic cb;
        gpt_pkg::gpt_mode_t md;
        sel = 3'h0;
        a = 1'b0;
        b = 1'b0;
        ca = 1'b0;
        cb = 1'b0;
        md = gpt_pkg::GPT_TIMER;
        en = 5'h00;
        dn = 5'h00;
        cap = 3'h0;
        rld_arm = 3'h0;
        for (int i = 0; i < 3; i++) begin
            sel = ctl_r[i][`GPT_SEL_HI:`GPT_SEL_LO];
            md = gpt_pkg::gpt_mode_t'(ctl_r[i][`GPT_MODE_HI:`GPT_MODE_LO]);
            a = sync2_r.timer_input_pin[i];
            b = sync2_r.direction_input_pin[i];
            ca = rise.timer_input_pin[i] | fall.timer_input_pin[i];
            cb = rise.direction_input_pin[i] | fall.direction_input_pin[i];
            dn[i] = ctl_r[i][`GPT_DOWN] ^ (ctl_r[i][`GPT_EXTDIR] & b);
            case (md)
                gpt_pkg::GPT_TIMER: begin
                    en[i] = pre_tick(pre_r, 4'(G1_SH) + {1'b0, sel});
                end
                gpt_pkg::GPT_GATE_LO: begin
                    en[i] = pre_tick(pre_r, 4'(G1_SH) + {1'b0, sel}) & ~a;
                end
                gpt_pkg::GPT_GATE_HI: begin
                    en[i] = pre_tick(pre_r, 4'(G1_SH) + {1'b0, sel}) & a;
                end
                gpt_pkg::GPT_COUNTER: begin
                    if (sel[2] && i != 1) begin
                        en[i] = edge_hit(sel[1:0], otl_ev_r[0], otl_ev_r[1]);
                    end else begin
                        en[i] = edge_hit(sel[1:0], rise.timer_input_pin[i],
                                         fall.timer_input_pin[i]);
                    end
                end
                gpt_pkg::GPT_INCR: begin
                    // Track A leading B counts up; simultaneous changes are ignored
                    en[i] = ca ^ cb;
                    dn[i] = ctl_r[i][`GPT_DOWN] ^ (ca ? (a == b) : (a != b));
                end
                gpt_pkg::GPT_RELOAD: begin
                    rld_arm[i] = (i != 1);
                end
                gpt_pkg::GPT_CAPTURE: begin
                    cap[i] = (i != 1) && edge_hit(sel[1:0], rise.timer_input_pin[i],
                                                  fall.timer_input_pin[i]);
                end
                default: begin
                    en[i] = 1'b0;
                end
            endcase
            en[i] = en[i] & ctl_r[i][`GPT_RUN];
        end
        for (int i = 3; i < 5; i++) begin
            sel = ctl_r[i][`GPT_SEL_HI:`GPT_SEL_LO];
            md = gpt_pkg::gpt_mode_t'(ctl_r[i][`GPT_MODE_HI:`GPT_MODE_LO]);
            dn[i] = ctl_r[i][`GPT_DOWN];
            if (i == 3 && md == gpt_pkg::GPT_COUNTER) begin
                en[i] = sotl_ev_r;
            end else begin
                en[i] = pre_tick(pre_r, 4'(G2_SH) + {1'b0, sel});
            end
            en[i] = en[i] & ctl_r[i][`GPT_RUN];
        end
        for (int i = 0; i < 5; i++) begin
            wrap[i] = en[i] & wraps(val_r[i], dn[i]);
        end
    end

    // Reload and second capture triggers
    always_comb begin
        logic [2:0] sel;
        logic src;
        sel = 3'h0;
        src = 1'b0;
        otl_rise = wrap[1] & ~core_toggle_latch_r;
        otl_fall = wrap[1] & core_toggle_latch_r;
        rld = 3'h0;
        for (int i = 0; i < 3; i += 2) begin
            sel = ctl_r[i][`GPT_SEL_HI:`GPT_SEL_LO];
            if (sel[2]) begin
                rld[i] = rld_arm[i] & edge_hit(sel[1:0], otl_rise, otl_fall);
            end else begin
                rld[i] = rld_arm[i] & edge_hit(sel[1:0], rise.timer_input_pin[i],
                                               fall.timer_input_pin[i]);
            end
        end
        case (ctl_r[3][`GPT_CSRC_HI:`GPT_CSRC_LO])
            2'h0: src = edge_hit(ctl_r[3][`GPT_CEDGE_HI:`GPT_CEDGE_LO],
                                 rise.capture_input_pin, fall.capture_input_pin);
            2'h1: src = rise.timer_input_pin[1] | fall.timer_input_pin[1];
            2'h2: src = rise.direction_input_pin[1] | fall.direction_input_pin[1];
            2'h3: src = rise.timer_input_pin[1] | fall.timer_input_pin[1] |
                        rise.direction_input_pin[1] | fall.direction_input_pin[1];
            default: src = 1'b0;
        endcase
        scap = ctl_r[3][`GPT_CAPEN] & src;
        ev = {scap, wrap[4], wrap[3], wrap[2] | cap[2] | rld[2], wrap[1],
              wrap[0] | cap[0] | rld[0]};
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 5; i++) begin
                ctl_r[i] <= `GPT_CTL_RST;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                // Bit 10 is latch readback on the two cores, masked on aux low and high, but a source select on second aux
                if (wr_ctl[i]) begin
                    ctl_r[i] <= lanes(ctl_r[i], wb_dat_i, wb_sel_i) &
                                ((i == 3) ? 16'hFFFF : `GPT_CTL_WMASK);
                end
            end
        end
    end

    // Timer values; software write wins over hardware in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 5; i++) begin
                val_r[i] <= `GPT_VAL_RST;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (wr_val[i]) begin
                    val_r[i] <= lanes(val_r[i], wb_dat_i, wb_sel_i);
                end else if (i == 1 && rld[0]) begin
                    val_r[i] <= val_r[0];
                end else if (i == 1 && rld[2]) begin
                    val_r[i] <= val_r[2];
                end else if (cap[i % 3] && i != 1 && i < 3) begin
                    val_r[i] <= val_r[1];
                end else if (i == 3 && scap && ctl_r[3][`GPT_CAPCLR]) begin
                    val_r[i] <= 16'h0000;
                end else if (i == 4 && wrap[4] && ctl_r[4][`GPT_RLDEN]) begin
                    val_r[i] <= capture_reload_reg_r;
                end else if (en[i]) begin
                    val_r[i] <= step(val_r[i], dn[i]);
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            capture_reload_reg_r <= `GPT_VAL_RST;
        end else if (wr_cap) begin
            capture_reload_reg_r <= lanes(capture_reload_reg_r, wb_dat_i, wb_sel_i);
        end else if (scap) begin
            capture_reload_reg_r <= val_r[3];
        end
    end

    // Toggle latches and their change events for chained timers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_toggle_latch_r <= 1'b0;
            second_toggle_latch_r <= 1'b0;
            otl_ev_r <= 2'h0;
            sotl_ev_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            core_toggle_latch_r <= core_toggle_latch_r ^ wrap[1];
            second_toggle_latch_r <= second_toggle_latch_r ^ wrap[4];
            otl_ev_r <= {otl_fall, otl_rise};
            sotl_ev_r <= wrap[4];
            out_r <= ctl_r[1][`GPT_OUTEN] & core_toggle_latch_r;
        end
    end

    // Interrupt nodes; a hardware event wins over a clearing write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int j = 0; j < 6; j++) begin
                node_r[j] <= `GPT_NODE_RST;
            end
            req_r <= 6'h00;
        end else begin
            for (int j = 0; j < 6; j++) begin
                if (wr_node[j] && wb_sel_i[0]) begin
                    node_r[j] <= wb_dat_i[7:0];
                end
                if (ev[j]) begin
                    node_r[j][`GPT_IR] <= 1'b1;
                end
                req_r[j] <= node_r[j][`GPT_IR] & node_r[j][`GPT_IE];
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !ack_r;
    endsequence

    sequence s_bus_ans;
        ack_r ##1 !ack_r;
    endsequence

    a_bus_ack_once: assert property (s_bus_req |=> s_bus_ans)
        else $error("bus ack not a single cycle after request");

    a_core_latch_flip: assert property (
        wrap[1] |=> core_toggle_latch_r != $past(core_toggle_latch_r))
        else $error("core toggle latch did not invert on wrap");

    a_core_wrap_up: assert property (
        en[1] && !dn[1] && val_r[1] == 16'hFFFF && !wr_val[1] && rld == 3'h0
        |=> val_r[1] == 16'h0000 && node_r[1][`GPT_IR])
        else $error("core did not wrap to zero with request flag");

    a_core_wrap_down: assert property (
        en[1] && dn[1] && val_r[1] == 16'h0000 && !wr_val[1] && rld == 3'h0
        |=> val_r[1] == 16'hFFFF)
        else $error("core did not wrap to all ones");

    a_aux_held: assert property (
        ctl_r[0][`GPT_MODE_HI:`GPT_MODE_LO] inside {3'h4, 3'h5} && !wr_val[0] && !cap[0]
        |=> $stable(val_r[0]))
        else $error("aux low counted while in capture or reload role");

    a_aux_capture: assert property (
        cap[2] && !wr_val[2] |=> val_r[2] == $past(val_r[1]))
        else $error("aux high did not capture core value");

    a_core_reload: assert property (
        rld[0] && !wr_val[1] |=> val_r[1] == $past(val_r[0]))
        else $error("core not reloaded from aux low");

    a_timer_resolution: assert property (
        en[1] && ctl_r[1][`GPT_MODE_HI:`GPT_MODE_LO] inside {3'h0, 3'h2, 3'h3}
        |-> pre_r[2:0] == 3'h7)
        else $error("core counted faster than its resolution");

    a_second_reload: assert property (
        wrap[4] && ctl_r[4][`GPT_RLDEN] && !wr_val[4]
        |=> val_r[4] == $past(capture_reload_reg_r))
        else $error("second core not reloaded from capture register");

    a_second_capture: assert property (
        scap && !wr_cap |=> capture_reload_reg_r == $past(val_r[3]))
        else $error("capture register missed second aux value");

    a_latch_out: assert property (
        wrap[1] && ctl_r[1][`GPT_OUTEN] && !wr_ctl[1]
        |=> ##1 out_r == core_toggle_latch_r)
        else $error("toggle output pin not following latch");

endmodule

// ===== verif/general_purpose_timer_unit_bench.sv
// Self-checking bench of the timer unit, registers over classic Wishbone.
// Assumes the pin model below and the unit's assertions inside the design.
`timescale 1ns/1ps
module general_purpose_timer_unit_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    gpt_pkg::gpt_pins_t pins;
    logic toggle_output_pin_o;
    logic [5:0] node_req_o;
    logic [31:0] rd;
    int error_cnt = 0;
    int num_checks = 0;

    always #50 clk_i = ~clk_i;

    gpt_unit u_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .pins_i(pins),
        .toggle_output_pin_o(toggle_output_pin_o),
        .node_req_o(node_req_o)
    );

    gpt_pin_model u_pins (
        .clk_i(clk_i),
        .pins_o(pins)
    );

    task automatic stop_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask

    // Single classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            stop_test();
        end
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [15:0] exp, input string nm);
        wb(1'b0, adr, 16'h0000);
        chk(nm, exp, rd[15:0]);
    endtask

    task automatic t_reset();
        rdchk(8'h04, 16'h0000, "core ctl reset");
        wb(1'b1, 8'h44, 16'hFFFF);
        rdchk(8'h44, 16'h0000, "unmapped read");
    endtask

    task automatic t_count();
        wb(1'b1, 8'h18, 16'h0000);
        wb(1'b1, 8'h04, 16'h0049);
        repeat (3) u_pins.pulse(5);
        rdchk(8'h18, 16'h0003, "core count");
    endtask

    task automatic t_gate();
        wb(1'b1, 8'h18, 16'h0000);
        wb(1'b1, 8'h04, 16'h0058);
        repeat (40) @(posedge clk_i);
        rdchk(8'h18, 16'h0000, "gated closed");
        u_pins.hold(5, 80);
        rdchk(8'h18, 16'h000A, "gated open");
    endtask

    task automatic t_wrap();
        wb(1'b1, 8'h30, 16'h0040);
        wb(1'b1, 8'h18, 16'h0000);
        wb(1'b1, 8'h04, 16'h02C9);
        u_pins.pulse(5);
        rdchk(8'h18, 16'hFFFF, "core underflow");
        chk("toggle pin", 16'h0001, {15'h0000, toggle_output_pin_o});
        chk("core node", 16'h0001, {15'h0000, node_req_o[1]});
        rdchk(8'h30, 16'h00C0, "core node reg");
        rdchk(8'h04, 16'h06C9, "core latch");
        wb(1'b1, 8'h04, 16'h0249);
        u_pins.pulse(5);
        rdchk(8'h18, 16'h0000, "core overflow");
        chk("toggle pin back", 16'h0000, {15'h0000, toggle_output_pin_o});
    endtask

    task automatic t_capture();
        wb(1'b1, 8'h04, 16'h0000);
        wb(1'b1, 8'h18, 16'hA5A5);
        wb(1'b1, 8'h14, 16'h0000);
        wb(1'b1, 8'h00, 16'h0069);
        wb(1'b1, 8'h1C, 16'h0000);
        wb(1'b1, 8'h08, 16'h0069);
        u_pins.pulse(4);
        rdchk(8'h14, 16'hA5A5, "aux capture");
        u_pins.pulse(6);
        rdchk(8'h1C, 16'hA5A5, "aux high capture");
        rdchk(8'h18, 16'hA5A5, "core held");
        rdchk(8'h14, 16'hA5A5, "aux low held");
    endtask

    task automatic t_reload();
        wb(1'b1, 8'h14, 16'h0BEE);
        wb(1'b1, 8'h00, 16'h0021);
        u_pins.pulse(4);
        rdchk(8'h18, 16'h0BEE, "core reload");
        wb(1'b1, 8'h18, 16'h0000);
        wb(1'b1, 8'h14, 16'h0000);
        wb(1'b1, 8'h1C, 16'h0007);
        wb(1'b1, 8'h00, 16'h0025);
        wb(1'b1, 8'h08, 16'h0026);
        wb(1'b1, 8'h04, 16'h00C9);
        u_pins.pulse(5);
        rdchk(8'h18, 16'h0000, "reload on latch rise");
        u_pins.pulse(5);
        rdchk(8'h18, 16'h0007, "reload on latch fall");
    endtask

    task automatic t_second();
        wb(1'b1, 8'h20, 16'h1234);
        wb(1'b1, 8'h0C, 16'h3100);
        u_pins.pulse(0);
        rdchk(8'h28, 16'h1234, "capture reg");
        rdchk(8'h20, 16'h0000, "second aux clear");
        wb(1'b1, 8'h20, 16'h5678);
        wb(1'b1, 8'h0C, 16'h1400);
        u_pins.pulse(5);
        rdchk(8'h28, 16'h5678, "capture from core pin");
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_count();
        t_gate();
        t_wrap();
        t_capture();
        t_reload();
        t_second();
        stop_test();
    end
endmodule

// ===== verif/gpt_pin_model.sv
// Far-side model of the timer unit: gate, count, direction and capture pins.
// Assumes the bench calls its tasks from a process synchronised to clk_i.
`timescale 1ns/1ps
module gpt_pin_model (
    input wire logic clk_i,
    output gpt_pkg::gpt_pins_t pins_o
);
    initial begin
        pins_o = '0;
    end

    // Pulse held three cycles high and four low, longer than the two-cycle minimum
    task automatic pulse(input int idx);
        @(posedge clk_i);
        pins_o[idx] <= 1'b1;
        repeat (3) @(posedge clk_i);
        pins_o[idx] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // Level held high for n cycles, then low for four
    task automatic hold(input int idx, input int n);
        @(posedge clk_i);
        pins_o[idx] <= 1'b1;
        repeat (n) @(posedge clk_i);
        pins_o[idx] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
endmodule
